/* File: logic/mscs_cfg.svh */
// Constants of the multi-setup conversion sequencer.
`ifndef MSCS_CFG_SVH
`define MSCS_CFG_SVH

// Serial word layout.
`define MSCS_BYTE_BITS     8
`define MSCS_LAST_BYTE_BIT 3'h7
`define MSCS_WORD_BITS     24
`define MSCS_WORD_MSB      5'h17
`define MSCS_EXIT_BYTE     8'hFF
`define MSCS_CONV_CAL_CODE 3'h0
`define MSCS_CAL_GAIN_BIT  1

// Setup store and physical channels.
`define MSCS_SETUPS        16
`define MSCS_CHANNELS      8
`define MSCS_FIRST_SETUP   4'h0

// Timing: clock period and width of the new-set pulse on the serial output.
`define MSCS_CLK_NS        20
`define MSCS_PULSE_NS      40
`define MSCS_PULSE_CYC     ((`MSCS_PULSE_NS + `MSCS_CLK_NS - 1) / `MSCS_CLK_NS)

`endif

/* File: logic/mscs_pkg.sv */
// Types of the multi-setup conversion sequencer.
package mscs_pkg;

  // Configuration bits that select the conversion mode.
  typedef struct packed {
    logic       multi_setup_select;
    logic       loop_repeat_select;
    logic       read_wait_select;
    logic [3:0] setup_depth_field;
  } mscs_cfg_t;

  // Command byte as it arrives on the serial input, first bit on top.
  typedef struct packed {
    logic       command_flag_bit;
    logic [3:0] setup_pointer_field;
    logic [2:0] calibration_type_field;
  } mscs_cmd_t;

  // Serial port states.
  typedef enum logic [2:0] {
    MSCS_S_CMD,
    MSCS_S_CAL,
    MSCS_S_BUSY,
    MSCS_S_READY,
    MSCS_S_FLAG,
    MSCS_S_DATA
  } mscs_port_t;

  // Conversion engine states.
  typedef enum logic [1:0] {
    MSCS_C_IDLE,
    MSCS_C_WAIT,
    MSCS_C_PUB,
    MSCS_C_HOLD
  } mscs_conv_t;

endpackage

/* File: logic/mscs_sequencer.sv */
// Conversion and calibration sequencer behind a three-wire serial port.
`timescale 1ns/1ps
`include "mscs_cfg.svh"

// Function
// - Multi-setup modes ignore the command pointer and use the configured depth.
// - Multi-setup sets convert depth plus one setups, ascending from the first.
// - Repeated no-wait mode converts continuously, wrapping to the first setup.
// - A new no-wait set replaces the old one; partial reads become corrupted.
// - No-wait mode pulses the serial output high then low when a fresh set replaces an unread one.
// - A start command with multi-setup selected launches a sequence from the first setup.
// - Serial output goes low only after the last conversion of a set.
// - Eight host clocks open each read and clear the ready indication.
// - After the flag clocks, one 24-bit word per setup follows, in order.
// - An all-zero flag byte keeps the repeated mode running.
// - An all-ones flag byte ends repetition after the final set is read.
// - With-wait mode holds the next set until the current set is read.
// - With-wait mode starts the next set after an all-zero continue byte.
// - Calibration takes its channel and settings from the addressed setup.
// - Calibration completion drives serial output low and stores the result.
// - One offset and one gain register per physical channel; later overwrites.
// - Each calibration command performs exactly one calibration.
// - Calibration and single-setup commands use bits six to three as pointer.
// - Pointer value n selects setup n.
// - A single one-setup result is read in 32 clocks, then command mode.
// - Single multi-setup mode returns to command mode after the last word.
// - Results come out in conversion order.
// - Each word is shifted out most significant bit first.
// - No-wait mode converts in the background while the host reads.
module mscs_sequencer
  import mscs_pkg::*;
(
  input  wire logic                             CLOCK,
  input  wire logic                             RSTN,
  input  wire logic                             SCLK,
  input  wire logic                             SERIAL_DATA_IN,
  output logic                                  SERIAL_DATA_OUT,
  input  mscs_cfg_t                             CFG,
  output logic                                  CONV_REQ,
  output logic [3:0]                            CONV_SETUP,
  input  wire logic                             CONV_DONE,
  input  wire logic [`MSCS_WORD_BITS-1:0]       CONV_DATA,
  output logic                                  CAL_REQ,
  output logic [3:0]                            CAL_SETUP,
  output logic [2:0]                            CAL_TYPE,
  input  wire logic                             CAL_DONE,
  input  wire logic [2:0]                       CAL_CHANNEL,
  input  wire logic [`MSCS_WORD_BITS-1:0]       CAL_RESULT,
  input  wire logic [2:0]                       CAL_READ_CHANNEL,
  output logic [`MSCS_WORD_BITS-1:0]            CAL_OFFSET,
  output logic [`MSCS_WORD_BITS-1:0]            CAL_GAIN,
  output logic                                  DATA_MODE,
  output logic                                  BUSY
);

  // Link synchronisers and edge detection.
  logic                          sclk_s1_q;
  logic                          sclk_s2_q;
  logic                          sclk_s3_q;
  logic                          sdi_s1_q;
  logic                          sdi_s2_q;
  logic                          sclk_rise;
  logic                          sclk_fall;

  // Serial port state.
  mscs_port_t                    s_state_q;
  mscs_port_t                    s_state_d;
  logic [4:0]                    bit_q;
  logic [4:0]                    bit_d;
  logic [3:0]                    word_q;
  logic [3:0]                    word_d;
  logic [7:0]                    shift_q;
  logic [7:0]                    shift_d;
  logic                          exit_q;
  logic                          exit_d;
  logic                          cal_low_q;
  logic                          cal_low_d;
  logic                          done_q;
  logic                          done_d;
  logic [4:0]                    pulse_q;
  logic                          sdo_q;
  logic [7:0]                    byte_in;
  mscs_cmd_t                     cmd;
  logic                          cmd_go;
  logic                          cal_go;
  logic                          rearm;
  logic                          halt;
  logic                          cur_bit;
  logic                          level;

  // Conversion engine state.
  mscs_conv_t                    c_state_q;
  mscs_conv_t                    c_state_d;
  logic [3:0]                    idx_q;
  logic [3:0]                    idx_d;
  logic [3:0]                    cnt_q;
  logic [3:0]                    cnt_d;
  logic [3:0]                    first_q;
  logic [3:0]                    last_q;
  logic                          loop_q;
  logic                          wait_q;
  logic                          stop_q;
  logic                          req_d;
  logic                          publish;
  logic [3:0]                    start_first;

  // Result storage and calibration registers.
  logic [`MSCS_WORD_BITS-1:0]    stage_q  [`MSCS_SETUPS];
  logic [`MSCS_WORD_BITS-1:0]    fifo_q   [`MSCS_SETUPS];
  logic [`MSCS_WORD_BITS-1:0]    offset_q [`MSCS_CHANNELS];
  logic [`MSCS_WORD_BITS-1:0]    gain_q   [`MSCS_CHANNELS];
  logic [2:0]                    cal_type_q;

  // The second stage of each synchroniser is read by logic, and the third stage of the serial clock.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sdi_s1_q  <= 1'b0;
      sdi_s2_q  <= 1'b0;
    end
    else
    begin
      sclk_s1_q <= SCLK;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sdi_s1_q  <= SERIAL_DATA_IN;
      sdi_s2_q  <= sdi_s1_q;
    end
  end

  // Input sampled on rising serial clock, output moved on falling serial clock.
  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
  assign sclk_fall = ~sclk_s2_q & sclk_s3_q;

  // Byte completed by the current bit, and its command fields.
  assign byte_in     = {shift_q[6:0], sdi_s2_q};
  assign cmd         = mscs_cmd_t'(byte_in);
  assign start_first = CFG.multi_setup_select ? `MSCS_FIRST_SETUP : cmd.setup_pointer_field;

  // Serial port sequencing: command bytes, flag byte and data words.
  always_comb
  begin
    s_state_d = s_state_q;
    bit_d     = bit_q;
    word_d    = word_q;
    shift_d   = shift_q;
    exit_d    = exit_q;
    cal_low_d = cal_low_q;
    done_d    = done_q;
    cmd_go    = 1'b0;
    cal_go    = 1'b0;
    rearm     = 1'b0;
    halt      = 1'b0;
    case (s_state_q)
      MSCS_S_CMD:
        if (sclk_rise)
        begin
          shift_d   = byte_in;
          cal_low_d = 1'b0;
          bit_d     = bit_q + 5'h01;
          if (bit_q[2:0] == `MSCS_LAST_BYTE_BIT)
          begin
            bit_d = 5'h00;
            if (cmd.command_flag_bit && cmd.calibration_type_field == `MSCS_CONV_CAL_CODE)
            begin
              cmd_go    = 1'b1;
              s_state_d = MSCS_S_BUSY;
            end
            else if (cmd.command_flag_bit)
            begin
              cal_go    = 1'b1;
              s_state_d = MSCS_S_CAL;
            end
          end
        end
      MSCS_S_CAL:
        if (CAL_DONE)
        begin
          cal_low_d = 1'b1;
          s_state_d = MSCS_S_CMD;
        end
      MSCS_S_BUSY:
        if (publish)
          s_state_d = MSCS_S_READY;
      MSCS_S_READY, MSCS_S_FLAG:
        if (sclk_rise)
        begin
          shift_d   = byte_in;
          bit_d     = bit_q + 5'h01;
          s_state_d = MSCS_S_FLAG;
          if (bit_q[2:0] == `MSCS_LAST_BYTE_BIT)
          begin
            exit_d    = (byte_in == `MSCS_EXIT_BYTE);
            bit_d     = 5'h00;
            word_d    = 4'h0;
            s_state_d = MSCS_S_DATA;
          end
        end
      MSCS_S_DATA:
        // The last bit of a set stands until the host's falling clock, then the port moves on.
        if (sclk_fall && done_q)
        begin
          done_d = 1'b0;
          if (exit_q || !loop_q)
          begin
            halt      = 1'b1;
            s_state_d = MSCS_S_CMD;
          end
          else
          begin
            rearm     = wait_q;
            s_state_d = MSCS_S_BUSY;
          end
        end
        else if (sclk_rise)
        begin
          bit_d = bit_q + 5'h01;
          if (bit_q == `MSCS_WORD_MSB)
          begin
            bit_d  = 5'h00;
            word_d = word_q + 4'h1;
            done_d = (word_q == last_q);
          end
        end
      default:
        s_state_d = MSCS_S_CMD;
    endcase
  end

  // Serial port registers.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s_state_q <= MSCS_S_CMD;
      bit_q     <= 5'h00;
      word_q    <= 4'h0;
      shift_q   <= 8'h00;
      exit_q    <= 1'b0;
      cal_low_q <= 1'b0;
      done_q    <= 1'b0;
    end
    else
    begin
      s_state_q <= s_state_d;
      bit_q     <= bit_d;
      word_q    <= word_d;
      shift_q   <= shift_d;
      exit_q    <= exit_d;
      cal_low_q <= cal_low_d;
      done_q    <= done_d;
    end
  end

  // Mode captured with each start command so later configuration edits do not disturb a run.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      first_q <= 4'h0;
      last_q  <= 4'h0;
      loop_q  <= 1'b0;
      wait_q  <= 1'b0;
    end
    else if (cmd_go)
    begin
      first_q <= start_first;
      last_q  <= CFG.multi_setup_select ? CFG.setup_depth_field : 4'h0;
      loop_q  <= CFG.loop_repeat_select;
      wait_q  <= CFG.read_wait_select;
    end
  end

  // Conversion engine: walks the setups of a set and publishes it when complete.
  always_comb
  begin
    c_state_d = c_state_q;
    idx_d     = idx_q;
    cnt_d     = cnt_q;
    req_d     = 1'b0;
    publish   = 1'b0;
    case (c_state_q)
      MSCS_C_IDLE:
        if (cmd_go)
        begin
          idx_d     = start_first;
          cnt_d     = 4'h0;
          req_d     = 1'b1;
          c_state_d = MSCS_C_WAIT;
        end
      MSCS_C_WAIT:
        if (CONV_DONE)
        begin
          if (stop_q)
            c_state_d = MSCS_C_IDLE;
          else if (cnt_q == last_q)
            c_state_d = MSCS_C_PUB;
          else
          begin
            idx_d = idx_q + 4'h1;
            cnt_d = cnt_q + 4'h1;
            req_d = 1'b1;
          end
        end
      MSCS_C_PUB:
      begin
        publish = 1'b1;
        if (loop_q && !wait_q && !stop_q)
        begin
          idx_d     = first_q;
          cnt_d     = 4'h0;
          req_d     = 1'b1;
          c_state_d = MSCS_C_WAIT;
        end
        else if (loop_q && wait_q && !stop_q)
          c_state_d = MSCS_C_HOLD;
        else
          c_state_d = MSCS_C_IDLE;
      end
      MSCS_C_HOLD:
        if (halt)
          c_state_d = MSCS_C_IDLE;
        else if (rearm)
        begin
          idx_d     = first_q;
          cnt_d     = 4'h0;
          req_d     = 1'b1;
          c_state_d = MSCS_C_WAIT;
        end
      default:
        c_state_d = MSCS_C_IDLE;
    endcase
  end

  // Conversion engine registers; a halt stops the background run when the conversion in progress completes.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      c_state_q  <= MSCS_C_IDLE;
      idx_q      <= 4'h0;
      cnt_q      <= 4'h0;
      stop_q     <= 1'b0;
      CONV_REQ   <= 1'b0;
      CONV_SETUP <= 4'h0;
    end
    else
    begin
      c_state_q  <= c_state_d;
      idx_q      <= idx_d;
      cnt_q      <= cnt_d;
      stop_q     <= cmd_go ? 1'b0 : (stop_q | halt);
      CONV_REQ   <= req_d;
      CONV_SETUP <= idx_d;
    end
  end

  // Each result lands in the staging slot of its set position.
  always_ff @(posedge CLOCK)
  begin
    if (c_state_q == MSCS_C_WAIT && CONV_DONE)
      stage_q[cnt_q] <= CONV_DATA;
  end

  // A finished set replaces the readable copy entry by entry.
  genvar gi;
  generate
    for (gi = 0; gi < `MSCS_SETUPS; gi = gi + 1)
    begin : g_fifo
      always_ff @(posedge CLOCK)
      begin
        if (publish)
          fifo_q[gi] <= stage_q[gi];
      end
    end
  endgenerate

  // Calibration launch: one request per command, pointer names the setup.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      CAL_REQ    <= 1'b0;
      CAL_SETUP  <= 4'h0;
      cal_type_q <= 3'h0;
    end
    else
    begin
      CAL_REQ <= cal_go;
      if (cal_go)
      begin
        CAL_SETUP  <= cmd.setup_pointer_field;
        cal_type_q <= cmd.calibration_type_field;
      end
    end
  end
  assign CAL_TYPE = cal_type_q;

  // One offset and one gain register per physical channel; the latest result wins.
  generate
    for (gi = 0; gi < `MSCS_CHANNELS; gi = gi + 1)
    begin : g_cal
      always_ff @(posedge CLOCK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          offset_q[gi] <= '0;
          gain_q[gi]   <= '0;
        end
        else if (s_state_q == MSCS_S_CAL && CAL_DONE && CAL_CHANNEL == 3'(gi))
        begin
          if (cal_type_q[`MSCS_CAL_GAIN_BIT])
            gain_q[gi] <= CAL_RESULT;
          else
            offset_q[gi] <= CAL_RESULT;
        end
      end
    end
  endgenerate

  // Registered readback of the calibration store.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      CAL_OFFSET <= '0;
      CAL_GAIN   <= '0;
    end
    else
    begin
      CAL_OFFSET <= offset_q[CAL_READ_CHANNEL];
      CAL_GAIN   <= gain_q[CAL_READ_CHANNEL];
    end
  end

  // New-set pulse: a set that replaces an unread one raises the line briefly.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      pulse_q <= 5'h00;
    else if (publish && s_state_q == MSCS_S_READY)
      pulse_q <= 5'(`MSCS_PULSE_CYC);
    else if (pulse_q != 5'h00)
      pulse_q <= pulse_q - 5'h01;
  end

  // Serial output level per state; data bits go out most significant first.
  assign cur_bit = fifo_q[word_q][`MSCS_WORD_MSB - bit_q];
  assign level   = (s_state_q == MSCS_S_CMD)   ? ~cal_low_q :
                   (s_state_q == MSCS_S_READY) ? (pulse_q != 5'h00) :
                   1'b1;

  // The data bit changes only on a falling serial clock so the host samples it stable.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      sdo_q <= 1'b1;
    else if (s_state_q != MSCS_S_DATA)
      sdo_q <= level;
    else if (sclk_fall)
      sdo_q <= done_q ? 1'b1 : cur_bit;
  end

  // Status outputs.
  assign SERIAL_DATA_OUT       = sdo_q;
  assign DATA_MODE = (s_state_q != MSCS_S_CMD) && (s_state_q != MSCS_S_CAL);
  assign BUSY      = (c_state_q == MSCS_C_WAIT) || (s_state_q == MSCS_S_CAL);

endmodule

/* File: verif/mscs_sequencer_chk.sv */
// Port assertions for the multi-setup conversion sequencer.
`timescale 1ns/1ps
module mscs_sequencer_chk
  import mscs_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic        SCLK,
  input wire logic        SERIAL_DATA_IN,
  input wire logic        SERIAL_DATA_OUT,
  input mscs_cfg_t        CFG,
  input wire logic        CONV_REQ,
  input wire logic [3:0]  CONV_SETUP,
  input wire logic        CONV_DONE,
  input wire logic [23:0] CONV_DATA,
  input wire logic        CAL_REQ,
  input wire logic [3:0]  CAL_SETUP,
  input wire logic [2:0]  CAL_TYPE,
  input wire logic        CAL_DONE,
  input wire logic [2:0]  CAL_CHANNEL,
  input wire logic [23:0] CAL_RESULT,
  input wire logic [2:0]  CAL_READ_CHANNEL,
  input wire logic [23:0] CAL_OFFSET,
  input wire logic [23:0] CAL_GAIN,
  input wire logic        DATA_MODE,
  input wire logic        BUSY
);
  logic       out_q;
  logic [3:0] last_q;
  wire        no_wait  = CFG.loop_repeat_select && !CFG.read_wait_select;
  wire        last_set = CONV_SETUP == CFG.setup_depth_field;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  // Tracks whether a conversion is outstanding and which setup was asked last.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      out_q  <= 1'b0;
      last_q <= 4'h0;
    end
    else
    begin
      out_q <= CONV_REQ || (out_q && !CONV_DONE);
      if (CONV_REQ)
        last_q <= CONV_SETUP;
    end
  end

  // A calibration result lands while the readback channel points at it.
  sequence s_cal_store;
    CAL_DONE && CAL_READ_CHANNEL == CAL_CHANNEL ##1 $stable(CAL_READ_CHANNEL);
  endsequence

  // The last conversion of a set in a mode that waits for the reader.
  sequence s_set_end;
    CONV_DONE && CFG.multi_setup_select && last_set && !no_wait;
  endsequence

  a_conv_pulse: assert property (CONV_REQ |=> !CONV_REQ)
    else $error("conversion request longer than one cycle");
  a_one_outstanding: assert property (CONV_REQ |-> !out_q)
    else $error("second conversion request before the answer");
  a_setup_step: assert property (CONV_REQ && CFG.multi_setup_select && CONV_SETUP != 4'h0 |-> CONV_SETUP == last_q + 4'h1)
    else $error("setups not visited in ascending order");
  a_depth_bound: assert property (CONV_REQ && CFG.multi_setup_select |-> CONV_SETUP <= CFG.setup_depth_field)
    else $error("setup beyond the configured depth");
  a_first_setup: assert property ($rose(DATA_MODE) && CFG.multi_setup_select |-> CONV_REQ && CONV_SETUP == 4'h0)
    else $error("sequence did not start at the first setup");
  a_mid_high: assert property (CONV_DONE && CFG.multi_setup_select && !last_set && !no_wait |=> SERIAL_DATA_OUT [*3])
    else $error("ready shown before the set was complete");
  a_set_ready: assert property (s_set_end |-> ##[1:3] !SERIAL_DATA_OUT)
    else $error("ready not shown after the last conversion");
  a_cal_pulse: assert property (CAL_REQ |=> !CAL_REQ)
    else $error("calibration request longer than one cycle");
  a_cal_ready: assert property (CAL_DONE |-> ##[1:2] !SERIAL_DATA_OUT)
    else $error("serial output not low after calibration");
  a_cal_store: assert property (s_cal_store |=> (CAL_TYPE[1] ? CAL_GAIN : CAL_OFFSET) == $past(CAL_RESULT, 2))
    else $error("calibration result not stored for its channel");
  a_busy_high: assert property (BUSY && !no_wait |-> SERIAL_DATA_OUT)
    else $error("serial output low while work is in progress");
  a_exit_high: assert property ($fell(DATA_MODE) && !$past(CAL_DONE) && !$past(CAL_DONE, 2) |-> ##[0:2] SERIAL_DATA_OUT)
    else $error("serial output not high after leaving data mode");
endmodule

/* File: verif/mscs_host_model.sv */
// Host controller model that clocks the three-wire serial port.
`timescale 1ns/1ps
module mscs_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  logic [23:0] words [0:3];
  logic        q;

  // The serial clock stands low between frames.
  initial
  begin
    sclk = 1'b0;
    serial_data_in  = 1'b1;
  end

  // One serial clock: input set while low, output taken just before the next fall.
  task automatic bit_io(input logic d, output logic r);
    serial_data_in = d;
    repeat (4) @(negedge clk);
    sclk = 1'b1;
    repeat (4) @(negedge clk);
    r    = serial_data_out;
    sclk = 1'b0;
  endtask

  // Sends a command byte, first bit on top.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], q);
  endtask

  // Clears the flag with a continue or exit byte, then reads n words.
  task automatic read_set(input logic [7:0] flag, input int n);
    for (int i = 7; i >= 0; i--)
      bit_io(flag[i], q);
    for (int w = 0; w < n; w++)
      for (int b = 23; b >= 0; b--)
        bit_io(1'b0, words[w][b]);
    repeat (4) @(negedge clk);
  endtask
endmodule

/* File: verif/mscs_sequencer_tb.sv */
// Self-checking bench of the multi-setup conversion sequencer.
`timescale 1ns/1ps
module mscs_sequencer_tb
  import mscs_pkg::*;
;
  logic        clock = 1'b0;
  logic        rstn, sclk, serial_data_in, serial_data_out, conv_req, cal_req, data_mode, busy;
  logic        conv_done = 1'b0;
  logic        cal_done  = 1'b0;
  logic [3:0]  conv_setup, cal_setup, conv_set;
  logic [2:0]  cal_type, cal_read_channel;
  logic [2:0]  cal_channel = 3'h0;
  logic [23:0] conv_data   = 24'h000000;
  logic [23:0] cal_result  = 24'h000000;
  logic [23:0] cal_offset, cal_gain, cal_val;
  logic [23:0] exp_w [0:15];
  mscs_cfg_t   cfg;
  int          conv_lat, conv_cnt, n_conv, cal_cnt, n_cal, miscompares, n_checks;

  mscs_sequencer dut (
    .CLOCK(clock), .RSTN(rstn), .SCLK(sclk), .SERIAL_DATA_IN(serial_data_in), .SERIAL_DATA_OUT(serial_data_out), .CFG(cfg),
    .CONV_REQ(conv_req), .CONV_SETUP(conv_setup), .CONV_DONE(conv_done), .CONV_DATA(conv_data),
    .CAL_REQ(cal_req), .CAL_SETUP(cal_setup), .CAL_TYPE(cal_type), .CAL_DONE(cal_done),
    .CAL_CHANNEL(cal_channel), .CAL_RESULT(cal_result), .CAL_READ_CHANNEL(cal_read_channel),
    .CAL_OFFSET(cal_offset), .CAL_GAIN(cal_gain), .DATA_MODE(data_mode), .BUSY(busy)
  );

  mscs_host_model host (.clk(clock), .sclk(sclk), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

  // System clock at 50 MHz.
  always #10 clock = ~clock;

  // Converter and calibration back end; data lines change every cycle outside answers.
  always @(negedge clock)
  begin
    conv_done  <= 1'b0;
    cal_done   <= 1'b0;
    conv_data  <= ~conv_data;
    cal_result <= ~cal_result;
    if (conv_req)
    begin
      conv_cnt = conv_lat;
      conv_set = conv_setup;
    end
    else if (conv_cnt > 0)
    begin
      conv_cnt--;
      if (conv_cnt == 0)
      begin
        n_conv++;
        exp_w[conv_set] = {conv_set, 4'h0, n_conv[15:0]};
        conv_data <= {conv_set, 4'h0, n_conv[15:0]};
        conv_done <= 1'b1;
      end
    end
    if (cal_req)
    begin
      n_cal++;
      cal_cnt = 20;
    end
    else if (cal_cnt > 0)
    begin
      cal_cnt--;
      if (cal_cnt == 0)
      begin
        cal_result <= cal_val;
        cal_done   <= 1'b1;
      end
    end
  end

  // Compares one value and counts it.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits, bounded, for the serial output to show ready.
  task automatic wait_ready();
    int n;
    n = 0;
    while (serial_data_out !== 1'b0 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    chk({23'h0, serial_data_out}, 24'h000000);
  endtask

  // Compares the words read back against the results of setups 0 to n-1.
  task automatic chk_set(input int n);
    for (int k = 0; k < n; k++)
      chk(host.words[k], exp_w[k]);
  endtask

  // Port back in command mode with the output high.
  task automatic chk_idle();
    chk({22'h0, data_mode, serial_data_out}, 24'h000001);
  endtask

  // Single conversion on the fifteenth setup.
  task automatic t_single();
    cfg = '{1'b0, 1'b0, 1'b0, 4'h0};
    host.send_byte(8'hF0);
    wait_ready();
    chk({20'h0, conv_setup}, 24'h00000E);
    host.read_set(8'h00, 1);
    chk(host.words[0], exp_w[14]);
    chk_idle();
  endtask

  // Single multi-setup set; the pointer of the command must be ignored.
  task automatic t_mss();
    cfg = '{1'b1, 1'b0, 1'b0, 4'h2};
    host.send_byte(8'hA8);
    wait_ready();
    host.read_set(8'h00, 3);
    chk_set(3);
    chk_idle();
  endtask

  // Repeated sets with wait: nothing converts until the set is read.
  task automatic t_wait();
    int n;
    cfg = '{1'b1, 1'b1, 1'b1, 4'h1};
    host.send_byte(8'h80);
    wait_ready();
    n = n_conv;
    repeat (600) @(negedge clock);
    chk(24'(n_conv), 24'(n));
    host.read_set(8'h00, 2);
    chk_set(2);
    wait_ready();
    host.read_set(8'hFF, 2);
    chk_set(2);
    chk_idle();
  endtask

  // Repeated sets without wait: an unread set is replaced and announced.
  task automatic t_nowait();
    int n;
    conv_lat = 400;
    cfg      = '{1'b1, 1'b1, 1'b0, 4'h0};
    host.send_byte(8'h80);
    wait_ready();
    n = 0;
    while (serial_data_out !== 1'b1 && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    chk({23'h0, serial_data_out}, 24'h000001);
    wait_ready();
    chk({23'h0, n_conv >= 2}, 24'h000001);
    host.read_set(8'h00, 1);
    chk_set(1);
    wait_ready();
    host.read_set(8'hFF, 1);
    chk_set(1);
    chk_idle();
  endtask

  // Every calibration type once, then channel 1 again through another setup.
  task automatic t_cal();
    logic [2:0] ty;
    cfg = '{1'b0, 1'b0, 1'b0, 4'h0};
    for (int i = 1; i <= 8; i++)
    begin
      ty               = (i == 8) ? 3'h1 : 3'(i);
      cal_channel      = ty;
      cal_read_channel = ty;
      cal_val          = 24'h5A0000 + 24'(i);
      host.send_byte({1'b1, 4'(i), ty});
      wait_ready();
      repeat (2) @(negedge clock);
      chk({21'h0, cal_type}, {21'h0, ty});
      chk({20'h0, cal_setup}, 24'(i));
      chk(ty[1] ? cal_gain : cal_offset, cal_val);
      chk(24'(n_cal), 24'(i));
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence: reset, then the scenarios.
  initial
  begin
    rstn             = 1'b0;
    cfg              = '0;
    cal_read_channel = 3'h0;
    cal_val          = 24'h000000;
    conv_lat         = 30;
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    chk({21'h0, serial_data_out, data_mode, busy}, 24'h000004);
    t_single();
    t_mss();
    t_wait();
    t_cal();
    t_nowait();
    results();
  end

  // Watchdog well beyond the expected length of the run.
  initial
  begin
    repeat (60000) @(negedge clock);
    miscompares++;
    results();
  end
endmodule

bind mscs_sequencer mscs_sequencer_chk u_chk (
  .CLOCK(CLOCK), .RSTN(RSTN), .SCLK(SCLK), .SERIAL_DATA_IN(SERIAL_DATA_IN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .CFG(CFG),
  .CONV_REQ(CONV_REQ), .CONV_SETUP(CONV_SETUP), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
  .CAL_REQ(CAL_REQ), .CAL_SETUP(CAL_SETUP), .CAL_TYPE(CAL_TYPE), .CAL_DONE(CAL_DONE),
  .CAL_CHANNEL(CAL_CHANNEL), .CAL_RESULT(CAL_RESULT), .CAL_READ_CHANNEL(CAL_READ_CHANNEL),
  .CAL_OFFSET(CAL_OFFSET), .CAL_GAIN(CAL_GAIN), .DATA_MODE(DATA_MODE), .BUSY(BUSY)
);
